//--- core/ccwdt_cfg.svh
// constants of the crystal clocked watchdog: offsets, fields, resets, timing
`ifndef CCWDT_CFG_SVH
`define CCWDT_CFG_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define CCWDT_ADDR_W 8
`define CCWDT_OFF_CTRL 8'hc0
`define CCWDT_OFF_ISTAT 8'hc4
`define CCWDT_OFF_IEN 8'hc8
`define CCWDT_OFF_ICLR 8'hcc
`define CCWDT_OFF_COUNT 8'hd0

// ****************************************************************
// watchdog_control fields and reset values
// ****************************************************************
`define CCWDT_BIT_UNLOCK 0
`define CCWDT_BIT_EN 1
`define CCWDT_BIT_STATUS 2
`define CCWDT_BIT_RSP 3
`define CCWDT_PRE_LSB 4
`define CCWDT_PRE_MSB 7
`define CCWDT_RST_PRE 4'h7
`define CCWDT_RST_EN 1'b1
`define CCWDT_RST_RSP 1'b0
`define CCWDT_PRE_MAX_TIMED 4'h7
`define CCWDT_PRE_IMM_RESET 4'h8
`define CCWDT_PRE_IMM_DLOAD 4'h9

// ****************************************************************
// interrupt status bits
// ****************************************************************
`define CCWDT_IRQ_W 2
`define CCWDT_IRQ_TIMEOUT 0
`define CCWDT_IRQ_REJECT 1

// ****************************************************************
// timing
// ****************************************************************
`define CCWDT_CLK_HZ 20000000
`define CCWDT_XTAL_HZ 32768
`define CCWDT_CNT_W 16
`define CCWDT_TAP_BASE 9

`endif

//--- core/ccwdt_cnt_if.sv
// carrier between the watchdog control logic and its counter
`timescale 1ns/1ns
interface ccwdt_cnt_if
  import ccwdt_pkg::*;
#(
  parameter int CNT_W = 16
);
  logic tick;
  logic run;
  logic restart;
  ccwdt_pre_t pre;
  logic expire;
  logic [CNT_W-1:0] count;

  modport ctl (output tick, output run, output restart, output pre,
    input expire, input count);
  modport cnt (input tick, input run, input restart, input pre,
    output expire, output count);
endinterface : ccwdt_cnt_if

//--- core/ccwdt_counter.sv
// 16-bit crystal-tick counter with selectable expiry tap
`timescale 1ns/1ns
module ccwdt_counter
  import ccwdt_pkg::*;
#(
  parameter int CNT_W = `CCWDT_CNT_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  ccwdt_cnt_if.cnt cif
);
  logic [CNT_W-1:0] cnt_reg;
  logic expire_reg;
  logic [CNT_W-1:0] limit;
  logic timed;

  generate
    if (CNT_W < `CCWDT_TAP_BASE + 7)
    begin : g_bad_cnt
      $error("ccwdt_counter: counter too narrow for the longest tap");
    end
  endgenerate

  // last count before the tap bit pre+9 would set
  function automatic logic [CNT_W-1:0] tap_limit(input ccwdt_pre_t pre);
    logic [CNT_W-1:0] ones;
    ones = '1;
    if (ccwdt_pre_timed(pre))
      tap_limit = ones >> (CNT_W - `CCWDT_TAP_BASE - int'(pre));
    else
      tap_limit = ones;
  endfunction : tap_limit

  assign limit = tap_limit(cif.pre);
  assign timed = ccwdt_pre_timed(cif.pre);

  // restart wins over a tick in the same cycle: a kick is never late
  always_ff @(posedge clk)
  begin
    if (!rst_n || cif.restart || !cif.run)
      cnt_reg <= '0;
    else if (cif.tick && timed)
    begin
      if (cnt_reg == limit)
        cnt_reg <= '0;
      else
        cnt_reg <= CNT_W'(cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      expire_reg <= 1'b0;
    else
      expire_reg <= !cif.restart && cif.run && cif.tick && timed
        && (cnt_reg == limit);
  end

  assign cif.count = cnt_reg;
  assign cif.expire = expire_reg;

  tick_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    cif.run && !cif.restart && cif.tick && timed && cnt_reg != limit
    |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("counter did not advance on a crystal tick");

  tap_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(expire_reg) |-> $past(cnt_reg) == tap_limit($past(cif.pre)))
    else $error("expiry not at the selected tap");
endmodule : ccwdt_counter

//--- core/ccwdt_pkg.sv
// types and shared decode helpers of the crystal clocked watchdog
package ccwdt_pkg;
  `include "ccwdt_cfg.svh"

  typedef logic [3:0] ccwdt_pre_t;

  typedef enum logic [2:0]
  {
    CCWDT_REG_CTRL = 3'b000,
    CCWDT_REG_ISTAT = 3'b001,
    CCWDT_REG_IEN = 3'b010,
    CCWDT_REG_ICLR = 3'b011,
    CCWDT_REG_COUNT = 3'b100,
    CCWDT_REG_NONE = 3'b111
  } ccwdt_reg_t;

  // codes above the timed range never expire through the counter
  function automatic logic ccwdt_pre_timed(input ccwdt_pre_t pre);
    ccwdt_pre_timed = (pre <= `CCWDT_PRE_MAX_TIMED);
  endfunction : ccwdt_pre_timed
endpackage : ccwdt_pkg

//--- core/ccwdt_sync.sv
// two flip-flop synchroniser for levels that arrive from pins
`timescale 1ns/1ns
module ccwdt_sync
#(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  generate
    if (W < 1)
    begin : g_bad_w
      $error("ccwdt_sync: width must be at least one");
    end
  endgenerate

  // meta_reg feeds sync_reg and nothing else
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : ccwdt_sync

//--- core/ccwdt_top.sv
// crystal clocked watchdog: apb registers, unlock, lock, expiry response
`timescale 1ns/1ns
module ccwdt_top
  import ccwdt_pkg::*;
#(
  parameter int CNT_W = `CCWDT_CNT_W,
  parameter int ADDR_W = `CCWDT_ADDR_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sys_rst_n,
  input wire logic crystal_clock,
  input wire logic flash_lock_bit,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sys_reset_req,
  output logic download_reset_req,
  output logic wdog_irq,
  output logic irq
);
  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  generate
    if (ADDR_W < 8)
    begin : g_bad_addr
      $error("ccwdt_top: address too narrow for the register map");
    end
    if (`CCWDT_CLK_HZ < 4 * `CCWDT_XTAL_HZ)
    begin : g_bad_clk
      $error("ccwdt_top: core clock too slow to sample the crystal");
    end
  endgenerate

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [1:0] sync_out;
  logic xtal_prev_reg;
  logic tick;
  logic locked;
  logic setup;
  logic access;
  ccwdt_reg_t hit;
  logic ctrl_wr;
  logic ctrl_apply;
  logic rejected;
  logic kick;
  ccwdt_pre_t wr_pre;
  ccwdt_pre_t pre_reg;
  logic rsp_reg;
  logic en_reg;
  logic status_reg;
  logic unlock_reg;
  logic en_eff;
  logic rsp_eff;
  logic sys_reset_reg;
  logic dload_reg;
  logic wdog_irq_reg;
  logic [`CCWDT_IRQ_W-1:0] ist_reg;
  logic [`CCWDT_IRQ_W-1:0] ien_reg;
  logic [`CCWDT_IRQ_W-1:0] ist_set;
  logic [31:0] prdata_reg;
  logic [31:0] rd_value;

  ccwdt_cnt_if #(.CNT_W(CNT_W)) cif ();

  // ****************************************************************
  // pin synchronisers and crystal tick
  // ****************************************************************
  // lock input idles high (unlocked) until the flash level is sampled
  ccwdt_sync #(.W(2), .RST_VAL(2'b10)) u_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({flash_lock_bit, crystal_clock}),
    .sync_out(sync_out)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      xtal_prev_reg <= 1'b0;
    else
      xtal_prev_reg <= sync_out[0];
  end

  assign tick = sync_out[0] && !xtal_prev_reg;
  assign locked = !sync_out[1];

  // ****************************************************************
  // apb decode
  // ****************************************************************
  function automatic ccwdt_reg_t decode(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(`CCWDT_OFF_CTRL))
      decode = CCWDT_REG_CTRL;
    else if (a == ADDR_W'(`CCWDT_OFF_ISTAT))
      decode = CCWDT_REG_ISTAT;
    else if (a == ADDR_W'(`CCWDT_OFF_IEN))
      decode = CCWDT_REG_IEN;
    else if (a == ADDR_W'(`CCWDT_OFF_ICLR))
      decode = CCWDT_REG_ICLR;
    else if (a == ADDR_W'(`CCWDT_OFF_COUNT))
      decode = CCWDT_REG_COUNT;
    else
      decode = CCWDT_REG_NONE;
  endfunction : decode

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit = decode(paddr);
  assign pready = access;
  assign pslverr = access && (hit == CCWDT_REG_NONE);

  assign ctrl_wr = access && pwrite && (hit == CCWDT_REG_CTRL);
  assign ctrl_apply = ctrl_wr && unlock_reg;
  assign rejected = ctrl_wr && !unlock_reg && !pwdata[`CCWDT_BIT_UNLOCK];
  assign kick = ctrl_apply && pwdata[`CCWDT_BIT_EN];
  assign wr_pre = pwdata[`CCWDT_PRE_MSB:`CCWDT_PRE_LSB];

  // ****************************************************************
  // unlock step
  // ****************************************************************
  // any access at all consumes the unlock, so a stray write cannot
  // ride on an old unlock
  always_ff @(posedge clk)
  begin
    if (!rst_n || !sys_rst_n)
      unlock_reg <= 1'b0;
    else if (access)
      unlock_reg <= ctrl_wr && !unlock_reg
        && pwdata[`CCWDT_BIT_UNLOCK];
  end

  // ****************************************************************
  // watchdog_control fields
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n || !sys_rst_n)
      pre_reg <= `CCWDT_RST_PRE;
    else if (ctrl_apply)
      pre_reg <= wr_pre;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !sys_rst_n)
    begin
      en_reg <= `CCWDT_RST_EN;
      rsp_reg <= `CCWDT_RST_RSP;
    end
    else if (ctrl_apply && !locked)
    begin
      en_reg <= pwdata[`CCWDT_BIT_EN];
      rsp_reg <= pwdata[`CCWDT_BIT_RSP];
    end
  end

  assign en_eff = en_reg || locked;
  assign rsp_eff = rsp_reg && !locked;

  // a watchdog-caused reset arrives on sys_rst_n and leaves status alone
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      status_reg <= 1'b0;
    else if (cif.expire)
      status_reg <= 1'b1;
    else if (ctrl_apply && !pwdata[`CCWDT_BIT_STATUS])
      status_reg <= 1'b0;
  end

  // ****************************************************************
  // counter hookup
  // ****************************************************************
  assign cif.tick = tick;
  assign cif.run = en_eff;
  assign cif.restart = kick || !sys_rst_n;
  assign cif.pre = pre_reg;

  ccwdt_counter #(.CNT_W(CNT_W)) u_counter
  (
    .clk(clk),
    .rst_n(rst_n),
    .cif(cif)
  );

  // ****************************************************************
  // expiry response
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n || !sys_rst_n)
    begin
      sys_reset_reg <= 1'b0;
      dload_reg <= 1'b0;
    end
    else
    begin
      sys_reset_reg <= (cif.expire && !rsp_eff)
        || (ctrl_apply && wr_pre == `CCWDT_PRE_IMM_RESET);
      dload_reg <= ctrl_apply && wr_pre == `CCWDT_PRE_IMM_DLOAD;
    end
  end

  // no global mask input: this line goes straight to the top priority
  always_ff @(posedge clk)
  begin
    if (!rst_n || !sys_rst_n)
      wdog_irq_reg <= 1'b0;
    else if (cif.expire && rsp_eff)
      wdog_irq_reg <= 1'b1;
    else if (ctrl_apply && !pwdata[`CCWDT_BIT_STATUS])
      wdog_irq_reg <= 1'b0;
  end

  assign sys_reset_req = sys_reset_reg;
  assign download_reset_req = dload_reg;
  assign wdog_irq = wdog_irq_reg;

  // ****************************************************************
  // event status, enable and clear
  // ****************************************************************
  always_comb
  begin
    ist_set = '0;
    ist_set[`CCWDT_IRQ_TIMEOUT] = cif.expire;
    ist_set[`CCWDT_IRQ_REJECT] = rejected;
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ist_reg <= '0;
    else if (access && pwrite && hit == CCWDT_REG_ICLR)
      ist_reg <= (ist_reg & ~pwdata[`CCWDT_IRQ_W-1:0]) | ist_set;
    else
      ist_reg <= ist_reg | ist_set;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ien_reg <= '0;
    else if (access && pwrite && hit == CCWDT_REG_IEN)
      ien_reg <= pwdata[`CCWDT_IRQ_W-1:0];
  end

  assign irq = |(ist_reg & ien_reg);

  // ****************************************************************
  // read data, captured in the setup cycle
  // ****************************************************************
  always_comb
  begin
    rd_value = '0;
    case (hit)
      CCWDT_REG_CTRL:
      begin
        rd_value[`CCWDT_PRE_MSB:`CCWDT_PRE_LSB] = pre_reg;
        rd_value[`CCWDT_BIT_RSP] = rsp_eff;
        rd_value[`CCWDT_BIT_STATUS] = status_reg;
        rd_value[`CCWDT_BIT_EN] = en_eff;
        rd_value[`CCWDT_BIT_UNLOCK] = unlock_reg;
      end
      CCWDT_REG_ISTAT: rd_value[`CCWDT_IRQ_W-1:0] = ist_reg;
      CCWDT_REG_IEN: rd_value[`CCWDT_IRQ_W-1:0] = ien_reg;
      CCWDT_REG_COUNT: rd_value[CNT_W-1:0] = cif.count;
      default: rd_value = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata_reg <= '0;
    else if (setup && !pwrite)
      prdata_reg <= rd_value;
  end

  assign prdata = prdata_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_unlock;
    ctrl_wr && !unlock_reg && pwdata[`CCWDT_BIT_UNLOCK];
  endsequence

  sequence s_kick;
    kick ##1 cif.count == '0;
  endsequence

  reset_default_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> pre_reg == 4'h7 && en_reg && !rsp_reg)
    else $error("watchdog not armed at two seconds after reset");

  disable_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    !en_eff [*2] |-> cif.count == '0 && !cif.expire)
    else $error("disabled watchdog still counting");

  locked_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_wr && !unlock_reg |=> pre_reg == $past(pre_reg)
      && en_reg == $past(en_reg))
    else $error("control changed without unlock");

  unlock_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    unlock_reg && access |=> !unlock_reg)
    else $error("unlock survived a second access");

  unlock_arm_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_unlock and sys_rst_n |=> unlock_reg)
    else $error("unlock step not taken");

  flash_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    locked |-> en_eff && !rsp_eff)
    else $error("lock did not force enable and reset response");

  lock_pre_a: assert property (@(posedge clk) disable iff (!rst_n)
    locked && ctrl_apply && sys_rst_n |=> pre_reg == $past(wr_pre))
    else $error("timeout select not writable while locked");

  expiry_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    cif.expire && !rsp_eff && sys_rst_n |=> sys_reset_req && status_reg)
    else $error("expiry in reset mode gave no reset");

  expiry_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    cif.expire && rsp_eff && sys_rst_n |=> wdog_irq && !sys_reset_req)
    else $error("expiry in interrupt mode gave no interrupt");

  imm_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_apply && wr_pre == 4'h8 && sys_rst_n |=> sys_reset_req)
    else $error("code 8 did not reset at once");

  status_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    status_reg && !sys_rst_n |=> status_reg)
    else $error("watchdog reset cleared the status flag");

  kick_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    kick |-> s_kick)
    else $error("setting enable did not restart the counter");

  periodic_a: assert property (@(posedge clk) disable iff (!rst_n)
    cif.expire |-> cif.count == '0)
    else $error("counter not restarted after expiry");
endmodule : ccwdt_top

//--- dv/crystal_clocked_watchdog_tb_top.sv
// self-checking bench of the crystal clocked watchdog top
`timescale 1ns/1ns
`include "ccwdt_cfg.svh"
module crystal_clocked_watchdog_tb_top
  import ccwdt_pkg::*;
();
  typedef struct {string nm; logic [31:0] d; logic e;} ccwdt_exp_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sys_rst_n = 1'b1;
  logic crystal_clock = 1'b0;
  logic flash_lock_bit = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sys_reset_req;
  logic download_reset_req;
  logic wdog_irq;
  logic irq;
  int fails = 0;
  int comparisons = 0;
  int n;
  logic [31:0] seed = 32'h0000_0024;
  ccwdt_exp_t exp_q[$];
  ccwdt_exp_t cur;

  ccwdt_top i_ccwdt_top (.clk(clk), .rst_n(rst_n), .sys_rst_n(sys_rst_n),
    .crystal_clock(crystal_clock), .flash_lock_bit(flash_lock_bit),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_reset_req(sys_reset_req), .download_reset_req(download_reset_req),
    .wdog_irq(wdog_irq), .irq(irq));

  always #25 clk = ~clk;
  // crystal runs six core clocks per period to keep the run short
  always #150 crystal_clock = ~crystal_clock;

  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic report_and_stop();
    if (fails == 0 && comparisons > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // read results are matched against the oldest note at the access edge
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (exp_q.size() == 0)
      begin
        check("read order", 32'h0000_0001, 32'h0000_0000);
      end
      else
      begin
        cur = exp_q.pop_front();
        check(cur.nm, cur.d, prdata);
        check({cur.nm, " err"}, {31'h0, cur.e}, {31'h0, pslverr});
      end
    end
  end

  // ****************************************************************
  // bus and pin drivers
  // ****************************************************************
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 20)
    begin
      check("bus answer", 32'h0000_0001, 32'h0000_0000);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic e, input string nm);
    exp_q.push_back('{nm, d, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic ctl_wr(input logic [31:0] d);
    apb(1'b1, `CCWDT_OFF_CTRL, 32'h0000_0001);
    apb(1'b1, `CCWDT_OFF_CTRL, d);
  endtask : ctl_wr

  // sel: 0 reset, 1 download, 2 watchdog irq, 3 irq; n returns the wait
  task automatic wait_out(input int sel, input int lim, output int w);
    logic [3:0] o;
    w = 0;
    o = {irq, wdog_irq, download_reset_req, sys_reset_req};
    while (o[sel] !== 1'b1 && w < lim)
    begin
      @(negedge clk);
      w++;
      o = {irq, wdog_irq, download_reset_req, sys_reset_req};
    end
    @(posedge clk);
  endtask : wait_out

  task automatic sys_pulse();
    sys_rst_n <= 1'b0;
    @(posedge clk);
    sys_rst_n <= 1'b1;
    @(posedge clk);
  endtask : sys_pulse

  initial
  begin
    #2000000;
    fails++;
    report_and_stop();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`CCWDT_OFF_CTRL, 32'h0000_0072, 1'b0, "ctl reset");
    apb(1'b1, `CCWDT_OFF_CTRL, 32'h0000_0000);
    rd(`CCWDT_OFF_CTRL, 32'h0000_0072, 1'b0, "ctl locked");
    rd(`CCWDT_OFF_ISTAT, 32'h0000_0002, 1'b0, "refused flag");
    apb(1'b1, `CCWDT_OFF_ICLR, 32'h0000_0003);
    rd(`CCWDT_OFF_ISTAT, 32'h0000_0000, 1'b0, "istat clear");
    rd(8'h10, 32'h0000_0000, 1'b1, "unmapped");
    seed = lfsr(seed);
    apb(1'b1, `CCWDT_OFF_IEN, seed | 32'h0000_0001);
    rd(`CCWDT_OFF_IEN, {30'h0, seed[1], 1'b1}, 1'b0, "ien");
    ctl_wr(32'h0000_000a);
    rd(`CCWDT_OFF_CTRL, 32'h0000_000a, 1'b0, "ctl irq mode");
    wait_out(2, 4000, n);
    check("irq expiry", 32'h1, {31'h0, n > 3050 && n < 3110});
    check("irq line", 32'h1, {31'h0, irq});
    rd(`CCWDT_OFF_CTRL, 32'h0000_000e, 1'b0, "status set");
    rd(`CCWDT_OFF_ISTAT, 32'h0000_0001, 1'b0, "istat timeout");
    ctl_wr(32'h0000_000a);
    apb(1'b1, `CCWDT_OFF_ICLR, 32'h0000_0001);
    @(negedge clk);
    check("irq cleared", 32'h0, {30'h0, wdog_irq, irq});
    @(posedge clk);
    ctl_wr(32'h0000_0000);
    wait_out(0, 4000, n);
    check("disabled quiet", 32'h1, {31'h0, n == 4000});
    rd(`CCWDT_OFF_COUNT, 32'h0000_0000, 1'b0, "count held");
    ctl_wr(32'h0000_0002);
    wait_out(0, 4000, n);
    check("reset expiry", 32'h1, {31'h0, n > 3050 && n < 3110});
    sys_pulse();
    rd(`CCWDT_OFF_CTRL, 32'h0000_0076, 1'b0, "status kept");
    // the request pulse lasts one cycle, so watch from the unlock onwards
    for (int c = 8; c < 10; c++)
    begin
      fork
        ctl_wr({24'h0, c[3:0], 4'h6});
        wait_out(c - 8, 10, n);
      join
      check("immediate reset", 32'h1, {31'h0, n == 6});
      sys_pulse();
    end
    ctl_wr(32'h0000_007e);
    rd(`CCWDT_OFF_CTRL, 32'h0000_007e, 1'b0, "ctl rsp set");
    flash_lock_bit <= 1'b0;
    repeat (4) @(posedge clk);
    rd(`CCWDT_OFF_CTRL, 32'h0000_0076, 1'b0, "lock forced");
    ctl_wr(32'h0000_003c);
    rd(`CCWDT_OFF_CTRL, 32'h0000_0036, 1'b0, "lock pre");
    apb(1'b1, `CCWDT_OFF_CTRL, 32'h0000_0001);
    rd(`CCWDT_OFF_CTRL, 32'h0000_0037, 1'b0, "unlock seen");
    apb(1'b1, `CCWDT_OFF_CTRL, 32'h0000_0012);
    rd(`CCWDT_OFF_CTRL, 32'h0000_0036, 1'b0, "unlock lost");
    flash_lock_bit <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`CCWDT_OFF_CTRL, 32'h0000_0072, 1'b0, "pin reset");
    report_and_stop();
  end
endmodule : crystal_clocked_watchdog_tb_top
